// file: verilog/psff_top.sv
// psff_top: power stage fault status register behind an AXI4-Lite slave
// assumes fault detectors drive asynchronous level inputs, high = fault
//
// Contract
// - bit 31 is the OR of all faults and is the inverse of the active-low fault pin level
// - bit 30 shows a buck regulator fault while present
// - bit 28 shows any output overcurrent
// - bit 26 shows motor supply overvoltage
// - bit 25 is set by thermal warning or thermal shutdown
// - bit 23 shows thermal warning while present
// - bit 22 shows thermal shutdown while present
// - bits 21..16 flag each switch overcurrent, phase c high down to a low
// - bit 14 shows a one-time-programmable memory error
// - bit 13 shows buck regulator overcurrent
// - bit 12 shows buck regulator output undervoltage
// - bit 11 shows charge pump undervoltage
// - register sits at offset E0h and resets to all zeros
`timescale 1ns/1ns
`default_nettype none
module psff_top
    import psff_pkg::*;
(
    input  wire logic                aclk,
    input  wire logic                aresetn,
    // axi4-lite write address
    input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    // axi4-lite write data
    input  wire logic [DATA_W-1:0]   s_axi_wdata,
    input  wire logic [DATA_W/8-1:0] s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    // axi4-lite write response
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    // axi4-lite read address
    input  wire logic [ADDR_W-1:0]   s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    // axi4-lite read data
    output logic [DATA_W-1:0]        s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    // fault detector levels, asynchronous
    input  wire logic                buck_regulator_alarm,
    input  wire logic                supply_overvoltage_flag,
    input  wire logic                thermal_warning_flag,
    input  wire logic                thermal_shutdown_flag,
    input  wire logic                phase_c_high_side_overcurrent,
    input  wire logic                phase_c_low_side_overcurrent,
    input  wire logic                phase_b_high_side_overcurrent,
    input  wire logic                phase_b_low_side_overcurrent,
    input  wire logic                phase_a_high_side_overcurrent,
    input  wire logic                phase_a_low_side_overcurrent,
    input  wire logic                otp_error_flag,
    input  wire logic                buck_overcurrent_flag,
    input  wire logic                buck_undervoltage_flag,
    input  wire logic                charge_pump_undervoltage_flag,
    // outputs
    output logic                     fault_indicator_pin_n,
    output logic                     irq
);

    // write and read channel states
    typedef enum logic [1:0] {
        WR_COLLECT = 2'b01,
        WR_RESP    = 2'b10
    } psff_wr_state_t;

    typedef enum logic [1:0] {
        RD_IDLE = 2'b01,
        RD_RESP = 2'b10
    } psff_rd_state_t;

    localparam int IN_W = 14;

    // address decode, shared by the read and write paths
    function automatic psff_sel_t decode(input logic [ADDR_W-1:0] addr);
        psff_sel_t sel;
        sel = SEL_NONE;
        if (addr[ADDR_W-1:2] == OFF_FAULT_FLAGS[ADDR_W-1:2]) begin
            sel = SEL_FLAGS;
        end else if (addr[ADDR_W-1:2] == OFF_IRQ_STATUS[ADDR_W-1:2]) begin
            sel = SEL_STATUS;
        end else if (addr[ADDR_W-1:2] == OFF_IRQ_MASK[ADDR_W-1:2]) begin
            sel = SEL_MASK;
        end
        return sel;
    endfunction

    logic [IN_W-1:0]   raw_in;
    logic [IN_W-1:0]   det;
    logic [31:0]       flags;
    logic [31:0]       next_flags;
    logic              pin_n;
    logic              next_pin_n;

    psff_irq_if        irq_bus ();

    // gather detector levels in a fixed order for the synchroniser
    assign raw_in = {buck_regulator_alarm,
                     supply_overvoltage_flag,
                     thermal_warning_flag,
                     thermal_shutdown_flag,
                     phase_c_high_side_overcurrent,
                     phase_c_low_side_overcurrent,
                     phase_b_high_side_overcurrent,
                     phase_b_low_side_overcurrent,
                     phase_a_high_side_overcurrent,
                     phase_a_low_side_overcurrent,
                     otp_error_flag,
                     buck_overcurrent_flag,
                     buck_undervoltage_flag,
                     charge_pump_undervoltage_flag};

    // detector levels come from analog comparators on other clocks
    psff_sync #(
        .W      (IN_W),
        .STAGES (2)
    ) u_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .async_in (raw_in),
        .sync_out (det)
    );

    // fault flag word; live levels, no latching in this register
    always_comb begin
        next_flags = RST_FAULT_FLAGS;
        next_flags[BIT_BUCK_ALARM]     = det[13];
        next_flags[BIT_SUPPLY_OV]      = det[12];
        next_flags[BIT_THERMAL_WARN]   = det[11];
        next_flags[BIT_THERMAL_SHUT]   = det[10];
        next_flags[BIT_SWITCH_OC_LO +: SWITCH_COUNT] = det[9:4];
        next_flags[BIT_OVERCURRENT_SUM] = |det[9:4];
        next_flags[BIT_THERMAL_ANY]    = det[11] | det[10];
        next_flags[BIT_OTP_ERROR]      = det[3];
        next_flags[BIT_BUCK_OC]        = det[2];
        next_flags[BIT_BUCK_UNDERVOLTAGE_FLAG]        = det[1];
        next_flags[BIT_CHARGE_PUMP_UV] = det[0];
        next_flags[BIT_FAULT_SUMMARY]  = |next_flags[BIT_FAULT_SUMMARY-1:0];
        // pin and bit 31 share one source so they never disagree
        next_pin_n = ~next_flags[BIT_FAULT_SUMMARY];
    end

    // flag word and fault pin registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags <= RST_FAULT_FLAGS;
            pin_n <= 1'b1;
        end else begin
            flags <= next_flags;
            pin_n <= next_pin_n;
        end
    end

    assign fault_indicator_pin_n = pin_n;

    // each fault bit rising raises a sticky interrupt status bit
    assign irq_bus.event_set = next_flags & ~flags;

    psff_irq u_irq (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ib      (irq_bus.bank)
    );

    assign irq = irq_bus.irq_level;

    // write channel
    psff_wr_state_t    wr_state;
    psff_wr_state_t    next_wr_state;
    logic              aw_got;
    logic              next_aw_got;
    logic              w_got;
    logic              next_w_got;
    logic [ADDR_W-1:0] aw_addr;
    logic [ADDR_W-1:0] next_aw_addr;
    logic [31:0]       w_data;
    logic [31:0]       next_w_data;
    logic [3:0]        w_strb;
    logic [3:0]        next_w_strb;
    logic [1:0]        bresp;
    logic [1:0]        next_bresp;
    logic              aw_fire;
    logic              w_fire;
    logic [ADDR_W-1:0] eff_addr;
    logic [31:0]       eff_data;
    logic [3:0]        eff_strb;
    psff_sel_t         wr_sel;
    logic [31:0]       strb_bits;

    assign s_axi_awready = (wr_state == WR_COLLECT) && !aw_got;
    assign s_axi_wready  = (wr_state == WR_COLLECT) && !w_got;
    assign s_axi_bvalid  = (wr_state == WR_RESP);
    assign s_axi_bresp   = bresp;

    // address and data are taken in either order, then applied together
    always_comb begin
        aw_fire        = s_axi_awvalid && s_axi_awready;
        w_fire         = s_axi_wvalid && s_axi_wready;
        next_wr_state  = wr_state;
        next_aw_got    = aw_got;
        next_w_got     = w_got;
        next_aw_addr   = aw_addr;
        next_w_data    = w_data;
        next_w_strb    = w_strb;
        next_bresp     = bresp;
        eff_addr       = aw_got ? aw_addr : s_axi_awaddr;
        eff_data       = w_got ? w_data : s_axi_wdata;
        eff_strb       = w_got ? w_strb : s_axi_wstrb;
        wr_sel         = decode(eff_addr);
        for (int b = 0; b < 4; b++) begin
            strb_bits[b*8 +: 8] = {8{eff_strb[b]}};
        end
        irq_bus.clear      = '0;
        irq_bus.mask_we    = '0;
        irq_bus.mask_wdata = eff_data;
        case (wr_state)
            WR_COLLECT: begin
                if (aw_fire) begin
                    next_aw_got  = 1'b1;
                    next_aw_addr = s_axi_awaddr;
                end
                if (w_fire) begin
                    next_w_got  = 1'b1;
                    next_w_data = s_axi_wdata;
                    next_w_strb = s_axi_wstrb;
                end
                if ((aw_got || aw_fire) && (w_got || w_fire)) begin
                    next_bresp    = RESP_OKAY;
                    next_wr_state = WR_RESP;
                    case (wr_sel)
                        SEL_FLAGS: next_bresp = RESP_OKAY;
                        SEL_STATUS: irq_bus.clear = eff_data & strb_bits;
                        SEL_MASK: irq_bus.mask_we = eff_strb;
                        default: next_bresp = RESP_SLVERR;
                    endcase
                end
            end
            WR_RESP: begin
                if (s_axi_bready) begin
                    next_wr_state = WR_COLLECT;
                    next_aw_got   = 1'b0;
                    next_w_got    = 1'b0;
                end
            end
            default: begin
                next_wr_state = WR_COLLECT;
                next_aw_got   = 1'b0;
                next_w_got    = 1'b0;
            end
        endcase
    end

    // write channel registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state <= WR_COLLECT;
            aw_got   <= 1'b0;
            w_got    <= 1'b0;
            aw_addr  <= '0;
            w_data   <= '0;
            w_strb   <= '0;
            bresp    <= RESP_OKAY;
        end else begin
            wr_state <= next_wr_state;
            aw_got   <= next_aw_got;
            w_got    <= next_w_got;
            aw_addr  <= next_aw_addr;
            w_data   <= next_w_data;
            w_strb   <= next_w_strb;
            bresp    <= next_bresp;
        end
    end

    // read channel
    psff_rd_state_t    rd_state;
    psff_rd_state_t    next_rd_state;
    logic [31:0]       rdata;
    logic [31:0]       next_rdata;
    logic [1:0]        rresp;
    logic [1:0]        next_rresp;

    assign s_axi_arready = (rd_state == RD_IDLE);
    assign s_axi_rvalid  = (rd_state == RD_RESP);
    assign s_axi_rdata   = rdata;
    assign s_axi_rresp   = rresp;

    // read data are captured at the address handshake and held
    always_comb begin
        next_rd_state = rd_state;
        next_rdata    = rdata;
        next_rresp    = rresp;
        case (rd_state)
            RD_IDLE: begin
                if (s_axi_arvalid) begin
                    next_rd_state = RD_RESP;
                    next_rresp    = RESP_OKAY;
                    case (decode(s_axi_araddr))
                        SEL_FLAGS: next_rdata = flags;
                        SEL_STATUS: next_rdata = irq_bus.status;
                        SEL_MASK: next_rdata = irq_bus.mask;
                        default: begin
                            next_rdata = '0;
                            next_rresp = RESP_SLVERR;
                        end
                    endcase
                end
            end
            RD_RESP: begin
                if (s_axi_rready) begin
                    next_rd_state = RD_IDLE;
                end
            end
            default: next_rd_state = RD_IDLE;
        endcase
    end

    // read channel registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_state <= RD_IDLE;
            rdata    <= '0;
            rresp    <= RESP_OKAY;
        end else begin
            rd_state <= next_rd_state;
            rdata    <= next_rdata;
            rresp    <= next_rresp;
        end
    end

endmodule // psff_top
`default_nettype wire

// file: common/psff_pkg.sv
// psff_pkg: constants for the power stage fault status block
// assumes a 32-bit AXI4-Lite register bus with byte addresses
`default_nettype none
package psff_pkg;

    // register bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // byte offsets of the registers
    localparam logic [7:0] OFF_FAULT_FLAGS = 8'hE0;
    localparam logic [7:0] OFF_IRQ_STATUS  = 8'hF0;
    localparam logic [7:0] OFF_IRQ_MASK    = 8'hF4;

    // reset values
    localparam logic [31:0] RST_FAULT_FLAGS = 32'h0000_0000;
    localparam logic [31:0] RST_IRQ_STATUS  = 32'h0000_0000;
    localparam logic [31:0] RST_IRQ_MASK    = 32'h0000_0000;

    // field positions in the fault flag word
    localparam int BIT_FAULT_SUMMARY    = 31;
    localparam int BIT_BUCK_ALARM       = 30;
    localparam int BIT_OVERCURRENT_SUM  = 28;
    localparam int BIT_SUPPLY_OV        = 26;
    localparam int BIT_THERMAL_ANY      = 25;
    localparam int BIT_THERMAL_WARN     = 23;
    localparam int BIT_THERMAL_SHUT     = 22;
    localparam int BIT_SWITCH_OC_LO     = 16; // phase a low side, up to bit 21
    localparam int BIT_OTP_ERROR        = 14;
    localparam int BIT_BUCK_OC          = 13;
    localparam int BIT_BUCK_UNDERVOLTAGE_FLAG          = 12;
    localparam int BIT_CHARGE_PUMP_UV   = 11;
    localparam int SWITCH_COUNT         = 6;

    // axi response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // register select
    typedef enum logic [3:0] {
        SEL_NONE   = 4'h1,
        SEL_FLAGS  = 4'h2,
        SEL_STATUS = 4'h4,
        SEL_MASK   = 4'h8
    } psff_sel_t;

endpackage
`default_nettype wire

// file: common/psff_irq_if.sv
// psff_irq_if: carrier between the top logic and the interrupt bank
// assumes both ends run on the same aclk
`timescale 1ns/1ns
`default_nettype none
interface psff_irq_if;
    logic [31:0] event_set;  // one-cycle set pulses
    logic [31:0] clear;      // one-cycle write-one-to-clear
    logic [31:0] mask_wdata;
    logic [3:0]  mask_we;    // byte strobes
    logic [31:0] status;
    logic [31:0] mask;
    logic        irq_level;

    modport owner (output event_set, output clear, output mask_wdata, output mask_we,
                   input status, input mask, input irq_level);
    modport bank  (input event_set, input clear, input mask_wdata, input mask_we,
                   output status, output mask, output irq_level);
endinterface
`default_nettype wire

// file: verilog/psff_sync.sv
// psff_sync: multi-stage synchroniser for a vector of level inputs
// assumes each bit is a slow level; no bus coherency between bits
`timescale 1ns/1ns
`default_nettype none
module psff_sync #(
    parameter int W      = 13,
    parameter int STAGES = 2
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] stage [STAGES];

    // fewer than two stages would expose metastability
    if (STAGES < 2) begin : g_chk
        $error("psff_sync needs at least two stages");
    end

    // shift chain; only the last stage is read outside
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < STAGES; i++) stage[i] <= '0;
        end else begin
            stage[0] <= async_in;
            for (int i = 1; i < STAGES; i++) stage[i] <= stage[i-1];
        end
    end

    assign sync_out = stage[STAGES-1];
endmodule // psff_sync
`default_nettype wire

// file: verilog/psff_irq.sv
// psff_irq: sticky interrupt status with write-one-to-clear and a mask
// assumes event and clear pulses are single aclk cycles
`timescale 1ns/1ns
`default_nettype none
module psff_irq
    import psff_pkg::*;
(
    input  wire logic aclk,
    input  wire logic aresetn,
    psff_irq_if.bank  ib
);
    logic [31:0] status;
    logic [31:0] mask;
    logic        irq_q;
    logic [31:0] next_status;
    logic [31:0] next_mask;
    logic        next_irq;

    // set wins over clear so an event in the clearing cycle survives
    always_comb begin
        next_status = (status & ~ib.clear) | ib.event_set;
        next_mask   = mask;
        for (int b = 0; b < 4; b++) begin
            if (ib.mask_we[b]) begin
                next_mask[b*8 +: 8] = ib.mask_wdata[b*8 +: 8];
            end
        end
        next_irq = |(next_status & next_mask);
    end

    // state registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status <= RST_IRQ_STATUS;
            mask   <= RST_IRQ_MASK;
            irq_q  <= 1'b0;
        end else begin
            status <= next_status;
            mask   <= next_mask;
            irq_q  <= next_irq;
        end
    end

    assign ib.status    = status;
    assign ib.mask      = mask;
    assign ib.irq_level = irq_q;
endmodule // psff_irq
`default_nettype wire

// file: verification/psff_top_assertions.sv
// psff_checker: bus handshake and flag word properties of psff_top
// assumes it is bound to psff_top and sees only its ports
`timescale 1ns/1ns
`default_nettype none
module psff_checker
    import psff_pkg::*;
(
    input wire logic              aclk,
    input wire logic              aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic              s_axi_awvalid,
    input wire logic              s_axi_awready,
    input wire logic              s_axi_wvalid,
    input wire logic              s_axi_wready,
    input wire logic [1:0]        s_axi_bresp,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic [DATA_W-1:0] s_axi_rdata,
    input wire logic [1:0]        s_axi_rresp,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_rready,
    input wire logic              fault_indicator_pin_n,
    input wire logic              irq
);
    // reserved positions of the flag word
    localparam logic [31:0] RSV = 32'h2900_87FF;
    logic [ADDR_W-1:0] rd_addr;
    logic [ADDR_W-1:0] next_rd_addr;
    logic              mapped;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // keep the read address, since the data answer comes a cycle later
    always_comb begin
        next_rd_addr = (s_axi_arvalid && s_axi_arready) ? s_axi_araddr : rd_addr;
    end
    always_ff @(posedge aclk) begin
        rd_addr <= next_rd_addr;
    end
    assign mapped = rd_addr == OFF_FAULT_FLAGS || rd_addr == OFF_IRQ_STATUS || rd_addr == OFF_IRQ_MASK;

    a_reset_idle: assert property (!$past(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid
        && fault_indicator_pin_n && !irq) else $error("outputs not idle after reset");
    a_write_flags_okay: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        && s_axi_awaddr == OFF_FAULT_FLAGS |=> s_axi_bvalid && s_axi_bresp == RESP_OKAY)
        else $error("write to flag word not answered okay");
    a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before taken");
    a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
        && $stable(s_axi_rresp)) else $error("read data changed before taken");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read not answered next cycle");
    a_flag_layout: assert property (s_axi_rvalid && rd_addr == OFF_FAULT_FLAGS |-> (s_axi_rdata & RSV) == 0
        && s_axi_rdata[31] == |s_axi_rdata[30:0] && s_axi_rdata[28] == |s_axi_rdata[21:16]
        && s_axi_rdata[25] == |s_axi_rdata[23:22]) else $error("flag word summary bits inconsistent");
    a_pin_mirror: assert property ($rose(s_axi_rvalid) && rd_addr == OFF_FAULT_FLAGS
        |-> s_axi_rdata[31] == !$past(fault_indicator_pin_n)) else $error("bit 31 differs from fault pin");
    a_unmapped_error: assert property (s_axi_rvalid |-> s_axi_rresp == (mapped ? RESP_OKAY : RESP_SLVERR)
        && (mapped || s_axi_rdata == 0)) else $error("read response code wrong for address");
endmodule // psff_checker

bind psff_top psff_checker u_psff_checker (.*);
`default_nettype wire

// file: verification/tb_power_stage_fault_status.sv
// tb_power_stage_fault_status: self-checking bench for psff_top
// assumes the checker is bound in separately; bench acts as bus master and fault source
`timescale 1ns/1ns
`default_nettype none
module tb_power_stage_fault_status;
    import psff_pkg::*;
    logic        aclk = 0, aresetn = 0;
    logic [7:0]  aw = 0, ar = 0;
    logic [31:0] wd = 0, rdat;
    logic        awv = 0, wv = 0, bq = 0, arv = 0, rq = 0;
    logic        awr, wr_rdy, bv, arr, rv, pin_n, irq;
    logic [1:0]  bresp, rresp;
    logic [13:0] flt = 0;
    int          n_errors = 0, checks_done = 0;

    psff_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aw), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy), .s_axi_bresp(bresp),
        .s_axi_bvalid(bv), .s_axi_bready(bq), .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rq),
        .buck_regulator_alarm(flt[0]), .supply_overvoltage_flag(flt[1]), .thermal_warning_flag(flt[2]),
        .thermal_shutdown_flag(flt[3]), .phase_a_low_side_overcurrent(flt[4]),
        .phase_a_high_side_overcurrent(flt[5]), .phase_b_low_side_overcurrent(flt[6]),
        .phase_b_high_side_overcurrent(flt[7]), .phase_c_low_side_overcurrent(flt[8]),
        .phase_c_high_side_overcurrent(flt[9]), .otp_error_flag(flt[10]), .buck_overcurrent_flag(flt[11]),
        .buck_undervoltage_flag(flt[12]), .charge_pump_undervoltage_flag(flt[13]),
        .fault_indicator_pin_n(pin_n), .irq(irq));

    // 10 MHz clock
    always #50 aclk = ~aclk;

    task automatic test_done();
        $display("checks %0d, mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h, want %h", $time, got, exp);
        end
    endtask

    // a bus wait that never ends counts against the run and stops it
    task automatic expire();
        n_errors++;
        $display("unexpected at %0t: bus answer never came", $time);
        test_done();
    endtask

    // write: address and data offered together, bready raised one cycle late to stall the answer
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic done;
        done = 0;
        aw <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        for (int n = 0; n < 30 && !done; n++) begin
            @(posedge aclk);
            if (awv && awr) awv <= 1'b0;
            if (wv && wr_rdy) wv <= 1'b0;
            if (bv && bq) done = 1;
            else if (bv) bq <= 1'b1;
        end
        if (!done) expire();
        r = bresp;
        bq <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic done;
        done = 0;
        ar <= a;
        arv <= 1'b1;
        for (int n = 0; n < 30 && !done; n++) begin
            @(posedge aclk);
            if (arv && arr) arv <= 1'b0;
            if (rv && rq) done = 1;
            else if (rv) rq <= 1'b1;
        end
        if (!done) expire();
        d = rdat;
        r = rresp;
        rq <= 1'b0;
    endtask

    // expected flag word from the fault levels
    function automatic logic [31:0] exp_flags(input logic [13:0] f);
        logic [31:0] e;
        e = 32'h0000_0000;
        e[30] = f[0];
        e[26] = f[1];
        e[23] = f[2];
        e[22] = f[3];
        e[21:16] = f[9:4];
        e[14:11] = {f[10], f[11], f[12], f[13]};
        e[28] = |f[9:4];
        e[25] = f[2] | f[3];
        e[31] = |f;
        return e;
    endfunction

    task automatic test_reset();
        logic [31:0] d;
        logic [1:0]  r;
        rd(OFF_FAULT_FLAGS, d, r);
        check(d, RST_FAULT_FLAGS);
        check(32'(r), 32'(RESP_OKAY));
        rd(OFF_IRQ_MASK, d, r);
        check(d, RST_IRQ_MASK);
        $display("test_reset done");
    endtask

    // each fault alone, then all together, then none
    task automatic test_each_fault();
        logic [31:0] d;
        logic [1:0]  r;
        for (int i = 0; i <= 15; i++) begin
            flt <= (i < 14) ? 14'(1 << i) : ((i == 14) ? 14'h3FFF : 14'h0000);
            repeat (4) @(posedge aclk);
            rd(OFF_FAULT_FLAGS, d, r);
            check(d, exp_flags(flt));
            check(32'(pin_n), 32'((i == 15) ? 1 : 0));
        end
        $display("test_each_fault done");
    endtask

    task automatic test_write_ignored();
        logic [31:0] d;
        logic [1:0]  r;
        flt <= 14'h0005;
        repeat (4) @(posedge aclk);
        wr(OFF_FAULT_FLAGS, 32'hFFFF_FFFF, r);
        check(32'(r), 32'(RESP_OKAY));
        rd(OFF_FAULT_FLAGS, d, r);
        check(d, exp_flags(14'h0005));
        $display("test_write_ignored done");
    endtask

    task automatic test_unmapped();
        logic [31:0] d;
        logic [1:0]  r;
        wr(8'hE4, 32'h1234_5678, r);
        check(32'(r), 32'(RESP_SLVERR));
        rd(8'h04, d, r);
        check(32'(r), 32'(RESP_SLVERR));
        check(d, 32'h0000_0000);
        $display("test_unmapped done");
    endtask

    // raise, mask, unmask, then clear a sticky event
    task automatic test_irq();
        logic [31:0] d;
        logic [1:0]  r;
        flt <= 14'h0000;
        repeat (4) @(posedge aclk);
        wr(OFF_IRQ_STATUS, 32'hFFFF_FFFF, r);
        wr(OFF_IRQ_MASK, 32'h4000_0000, r);
        flt <= 14'h0001;
        repeat (4) @(posedge aclk);
        check(32'(irq), 32'h0000_0001);
        rd(OFF_IRQ_STATUS, d, r);
        check(d, 32'hC000_0000);
        wr(OFF_IRQ_MASK, 32'h0000_0000, r);
        repeat (2) @(posedge aclk);
        check(32'(irq), 32'h0000_0000);
        wr(OFF_IRQ_MASK, 32'h4000_0000, r);
        flt <= 14'h0000;
        repeat (4) @(posedge aclk);
        check(32'(irq), 32'h0000_0001);
        wr(OFF_IRQ_STATUS, 32'hC000_0000, r);
        repeat (2) @(posedge aclk);
        check(32'(irq), 32'h0000_0000);
        rd(OFF_IRQ_STATUS, d, r);
        check(d, 32'h0000_0000);
        $display("test_irq done");
    endtask

    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        test_reset();
        test_each_fault();
        test_write_ignored();
        test_unmapped();
        test_irq();
        test_done();
    end
endmodule // tb_power_stage_fault_status
`default_nettype wire
